// file: verilog/urs_top.v
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ns
`include "urs_map.vh"

// Notes on behaviour
// [R1] Parity failure of a received character sets the parity error flag.
// [R2] Overrun flag rises only when FIFO is full and another character completes.
// [R3] Overrun character is dropped, never pushed into the FIFO.
// [R4] Overrun shows at once; a line status read clears it.
// [R5] Data ready flag is high exactly while the FIFO holds a word.
// [R6] Break, framing, parity status travel per character, shown at FIFO head.
// [R7] A line status read clears break, framing and parity flags.
// [R8] Line status interrupt: any of those four flags set and its enable set.
// [R9] Line status read drops that interrupt; writes to it do nothing.
// [R10] Modem status bit 5 shows the inverted peer-ready pin.
// [R11] Peer-ready change sets a flag; modem status read clears it.
// [R12] Modem interrupt: modem status bits 3..0 nonzero and its enable set.
// [R13] Writes to modem status are ignored.
// [R14] Idle timeout interrupt needs both the timeout enable and data enable.
// [R15] Idle counter restarts on every push and advances per baud tick.
// [R16] Counter equal to the 7-bit compare raises idle interrupt if enabled.
// [R17] Idle interrupt drops on a new word or an empty FIFO.
// [R18] Reserved bits read zero and ignore writes.
module urs_top (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`URS_AW-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [`URS_DW-1:0] wb_dat_i,
  output reg [`URS_DW-1:0] wb_dat_o,
  output reg wb_ack_o,
  input wire rx_char_valid_i,
  input wire [`URS_DATA_HI:0] rx_char_data_i,
  input wire rx_parity_err_i,
  input wire rx_frame_err_i,
  input wire rx_break_i,
  input wire baud_tick_i,
  input wire peer_ready_n_i,
  output reg rx_data_ready_o,
  output reg line_status_irq_o,
  output reg modem_irq_o,
  output reg rx_idle_irq_o,
  output reg irq_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Address match against a register offset, word aligned
  function hit;
    input [`URS_AW-1:0] adr;
    input [`URS_AW-1:0] off;
    begin
      hit = ({adr[`URS_AW-1:2], 2'b00} == off);
    end
  endfunction

  // Sticky flag update; a set in the clearing cycle wins
  function [`URS_IRQ_W-1:0] sticky;
    input [`URS_IRQ_W-1:0] cur;
    input [`URS_IRQ_W-1:0] set;
    input [`URS_IRQ_W-1:0] clr;
    begin
      sticky = (cur & ~clr) | set;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  reg [`URS_ENT_W-1:0] fifo_mem [0:`URS_FIFO_DEPTH-1];
  reg [`URS_FIFO_AW-1:0] wr_ptr_reg;
  reg [`URS_FIFO_AW-1:0] rd_ptr_reg;
  reg [`URS_CNT_W-1:0] count_reg;
  reg head_shown_reg;
  reg [`URS_IRQ_W-1:0] err_flags_reg;
  reg overrun_flag_reg;
  reg peer_ready_changed_reg;
  reg [`URS_IER_W-1:0] irq_enable_reg;
  reg [`URS_TOR_W-1:0] rx_idle_reg;
  reg [`URS_CMP_W-1:0] rx_idle_counter_reg;
  reg rx_idle_flag_reg;
  reg [`URS_IRQ_W-1:0] irq_status_reg;
  reg [`URS_IRQ_W-1:0] irq_mask_reg;
  reg [`URS_DW-1:0] rd_data;

  wire peer_ready_n_lvl;
  wire peer_ready_chg;

  ////////////////////////////////////////////////////////////////////////////////
  // Peer-ready pin crossing

  urs_sync3 u_peer_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(peer_ready_n_i),
    .level_o(peer_ready_n_lvl),
    .change_o(peer_ready_chg)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // A request is taken once; ack high blocks a second take
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire rd_acc = bus_req & ~wb_we_i;
  wire wr_acc = bus_req & wb_we_i & wb_sel_i[0]; // All fields sit in lane 0

  wire lsr_rd = rd_acc & hit(wb_adr_i, `URS_OFF_LSR);
  wire msr_rd = rd_acc & hit(wb_adr_i, `URS_OFF_MSR);
  wire ier_wr = wr_acc & hit(wb_adr_i, `URS_OFF_IER);
  wire tor_wr = wr_acc & hit(wb_adr_i, `URS_OFF_TOR);
  wire ist_wr = wr_acc & hit(wb_adr_i, `URS_OFF_IST);
  wire msk_wr = wr_acc & hit(wb_adr_i, `URS_OFF_IMSK);

  ////////////////////////////////////////////////////////////////////////////////
  // Receive FIFO control

  wire fifo_empty = (count_reg == `URS_CNT_RST);
  wire fifo_full = (count_reg == `URS_FIFO_FULL);
  wire [`URS_ENT_W-1:0] head = fifo_mem[rd_ptr_reg];

  // Reading the data register pops the head word
  wire pop = rd_acc & hit(wb_adr_i, `URS_OFF_RBR) & ~fifo_empty;
  wire push = rx_char_valid_i & ~fifo_full; // [R3]
  wire overrun_evt = rx_char_valid_i & fifo_full; // [R2]

  reg [`URS_CNT_W-1:0] count_next;

  // Occupancy follows push and pop, both allowed in one cycle
  always @* begin
    case ({push, pop})
      2'b10: count_next = count_reg + `URS_CNT_ONE;
      2'b01: count_next = count_reg - `URS_CNT_ONE;
      default: count_next = count_reg;
    endcase
  end

  // Storage holds error status beside each character; no reset needed
  always @(posedge clk_i) begin
    if (ce_i && push) begin
      fifo_mem[wr_ptr_reg] <= {rx_break_i, rx_frame_err_i, rx_parity_err_i,
        rx_char_data_i}; // [R1] [R6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line status flags

  // Head errors are copied into the flags once per head word
  wire reveal = ~fifo_empty & ~head_shown_reg;
  wire [`URS_IRQ_W-1:0] err_set = reveal ? head[`URS_ERR_HI:`URS_ERR_LO] : `URS_ERR_RST;
  wire [`URS_IRQ_W-1:0] err_next = sticky(err_flags_reg, err_set, {`URS_IRQ_W{lsr_rd}});
  wire overrun_next = overrun_evt | (overrun_flag_reg & ~lsr_rd); // [R4]

  ////////////////////////////////////////////////////////////////////////////////
  // Modem status

  wire peer_ready_changed_next = peer_ready_chg | (peer_ready_changed_reg & ~msr_rd); // [R11]

  ////////////////////////////////////////////////////////////////////////////////
  // Register next values

  wire [`URS_IER_W-1:0] ier_next = ier_wr ? wb_dat_i[`URS_IER_W-1:0] : irq_enable_reg;
  wire [`URS_TOR_W-1:0] tor_next = tor_wr ? wb_dat_i[`URS_TOR_W-1:0] : rx_idle_reg;
  wire [`URS_IRQ_W-1:0] msk_next = msk_wr ? wb_dat_i[`URS_IRQ_W-1:0] : irq_mask_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Idle timeout

  // Both enables must be set before the comparator may fire
  wire idle_en = rx_idle_reg[`URS_TOR_EN] & irq_enable_reg[`URS_IER_RDA]; // [R14]
  wire idle_hit = (rx_idle_counter_reg == rx_idle_reg[`URS_CMP_HI:0]); // [R16]

  reg [`URS_CMP_W-1:0] idle_cnt_next;
  reg idle_flag_next;

  // Counter saturates so a stale comparison cannot repeat after wrap
  always @* begin
    idle_cnt_next = rx_idle_counter_reg;
    if (push) begin
      idle_cnt_next = `URS_CNT_RST; // [R15]
    end else if (baud_tick_i && (rx_idle_counter_reg != `URS_CNT_MAX)) begin
      idle_cnt_next = rx_idle_counter_reg + `URS_CNT_ONE; // [R15]
    end
  end

  // Idle flag: clear on new word or empty FIFO, else set on a match
  always @* begin
    idle_flag_next = rx_idle_flag_reg;
    if (push || fifo_empty) begin
      idle_flag_next = 1'b0; // [R17]
    end else if (idle_en && idle_hit) begin
      idle_flag_next = 1'b1; // [R16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt lines and sticky status

  // Computed from next values so outputs line up with the flags
  wire lsi_next = ((|err_next) | overrun_next) & ier_next[`URS_IER_RLS]; // [R8] [R9]
  wire msi_next = peer_ready_changed_next & ier_next[`URS_IER_MS]; // [R12]
  wire [`URS_IRQ_W-1:0] ist_clr = ist_wr ? wb_dat_i[`URS_IRQ_W-1:0] : `URS_IRQ_RST;
  wire [`URS_IRQ_W-1:0] ist_next = sticky(irq_status_reg,
    {idle_flag_next, msi_next, lsi_next}, ist_clr);

  ////////////////////////////////////////////////////////////////////////////////
  // Read data mux

  // Unmapped and reserved bits return zero
  always @* begin
    rd_data = `URS_ZERO32; // [R18]
    case ({wb_adr_i[`URS_AW-1:2], 2'b00})
      `URS_OFF_RBR: begin
        if (!fifo_empty) begin
          rd_data[`URS_DATA_HI:0] = head[`URS_DATA_HI:0];
        end
      end
      `URS_OFF_IER: rd_data[`URS_IER_W-1:0] = irq_enable_reg;
      `URS_OFF_LSR: begin
        rd_data[`URS_LSR_ERR_HI:`URS_LSR_ERR_LO] = err_flags_reg; // [R6]
        rd_data[`URS_LSR_OVR] = overrun_flag_reg; // [R4]
        rd_data[`URS_LSR_RDY] = ~fifo_empty; // [R5]
      end
      `URS_OFF_MSR: begin
        rd_data[`URS_MSR_PLVL] = ~peer_ready_n_lvl; // [R10]
        rd_data[`URS_MSR_PCHG] = peer_ready_changed_reg;
      end
      `URS_OFF_TOR: rd_data[`URS_TOR_W-1:0] = rx_idle_reg;
      `URS_OFF_IST: rd_data[`URS_IRQ_W-1:0] = irq_status_reg;
      `URS_OFF_IMSK: rd_data[`URS_IRQ_W-1:0] = irq_mask_reg;
      default: rd_data = `URS_ZERO32;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, ack for a single cycle

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `URS_ZERO32;
    end else if (ce_i) begin
      wb_ack_o <= bus_req;
      if (rd_acc) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // FIFO pointers and head tracking

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= `URS_PTR_RST;
      rd_ptr_reg <= `URS_PTR_RST;
      count_reg <= `URS_CNT_RST;
      head_shown_reg <= 1'b0;
    end else if (ce_i) begin
      count_reg <= count_next;
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + `URS_PTR_ONE;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + `URS_PTR_ONE;
        head_shown_reg <= 1'b0; // Next head is revealed afresh
      end else if (reveal) begin
        head_shown_reg <= 1'b1; // [R6]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status flags and software registers

  // Line and modem status ignore writes and clear on reads; interrupt status bits clear where a one is written
  always @(posedge clk_i) begin
    if (rst_i) begin
      err_flags_reg <= `URS_ERR_RST;
      overrun_flag_reg <= 1'b0;
      peer_ready_changed_reg <= 1'b0;
      irq_enable_reg <= `URS_IER_RST;
      rx_idle_reg <= `URS_TOR_RST;
      irq_mask_reg <= `URS_IRQ_RST;
      irq_status_reg <= `URS_IRQ_RST;
    end else if (ce_i) begin
      err_flags_reg <= err_next; // [R1] [R7]
      overrun_flag_reg <= overrun_next; // [R2] [R4]
      peer_ready_changed_reg <= peer_ready_changed_next; // [R11] [R13]
      irq_enable_reg <= ier_next;
      rx_idle_reg <= tor_next; // [R18]
      irq_mask_reg <= msk_next;
      irq_status_reg <= ist_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Idle counter and flag

  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_idle_counter_reg <= `URS_CNT_RST;
      rx_idle_flag_reg <= 1'b0;
    end else if (ce_i) begin
      rx_idle_counter_reg <= idle_cnt_next;
      rx_idle_flag_reg <= idle_flag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  // Outputs track next state so they agree with the flags each cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_data_ready_o <= 1'b0;
      line_status_irq_o <= 1'b0;
      modem_irq_o <= 1'b0;
      rx_idle_irq_o <= 1'b0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      rx_data_ready_o <= (count_next != `URS_CNT_RST); // [R5]
      line_status_irq_o <= lsi_next; // [R8]
      modem_irq_o <= msi_next; // [R12]
      rx_idle_irq_o <= idle_flag_next; // [R16] [R17]
      irq_o <= |(ist_next & msk_next);
    end
  end

endmodule // urs_top

// file: verilog/urs_map.vh
`ifndef URS_MAP_VH
`define URS_MAP_VH

// Bus geometry
`define URS_AW 8
`define URS_DW 32
`define URS_ZERO32 32'h00000000

// Register byte offsets
`define URS_OFF_RBR 8'h00
`define URS_OFF_IER 8'h04
`define URS_OFF_LSR 8'h14
`define URS_OFF_MSR 8'h18
`define URS_OFF_TOR 8'h1C
`define URS_OFF_IST 8'h20
`define URS_OFF_IMSK 8'h24

// Line status fields
`define URS_LSR_RDY 0
`define URS_LSR_OVR 1
`define URS_LSR_ERR_HI 4
`define URS_LSR_ERR_LO 2

// Modem status fields
`define URS_MSR_PCHG 1
`define URS_MSR_PLVL 5

// Interrupt enable fields
`define URS_IER_W 4
`define URS_IER_RDA 0
`define URS_IER_RLS 2
`define URS_IER_MS 3

// Idle timeout fields
`define URS_TOR_W 8
`define URS_TOR_EN 7
`define URS_CMP_HI 6
`define URS_CMP_W 7
`define URS_CNT_MAX 7'h7F
`define URS_CNT_ONE 7'h01

// Sticky interrupt status layout
`define URS_IRQ_W 3
`define URS_IRQ_RLS 0
`define URS_IRQ_MS 1
`define URS_IRQ_TO 2

// Receive FIFO: entry is {break, framing, parity, data}
`define URS_FIFO_AW 6
`define URS_FIFO_DEPTH 64
`define URS_CNT_W 7
`define URS_FIFO_FULL 7'h40
`define URS_ENT_W 11
`define URS_DATA_HI 7
`define URS_ERR_HI 10
`define URS_ERR_LO 8
`define URS_PTR_ONE 6'h01

// Reset values
`define URS_IER_RST 4'h0
`define URS_TOR_RST 8'h00
`define URS_IRQ_RST 3'h0
`define URS_CNT_RST 7'h00
`define URS_PTR_RST 6'h00
`define URS_ERR_RST 3'h0
`define URS_PIN_N_RST 1'b1

`endif

// file: verilog/urs_sync3.v
`timescale 1ns/1ns
`include "urs_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Three-stage pin synchroniser; a new level counts once stages two and three agree
module urs_sync3 (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire pin_i,
  output reg level_o,
  output reg change_o
);

  reg meta_reg;
  reg stage2_reg;
  reg stage3_reg;

  // First stage feeds only the second, never any logic
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= `URS_PIN_N_RST;
      stage2_reg <= `URS_PIN_N_RST;
      stage3_reg <= `URS_PIN_N_RST;
      level_o <= `URS_PIN_N_RST;
      change_o <= 1'b0;
    end else if (ce_i) begin
      meta_reg <= pin_i;
      stage2_reg <= meta_reg;
      stage3_reg <= stage2_reg;
      change_o <= 1'b0;
      if ((stage2_reg == stage3_reg) && (stage3_reg != level_o)) begin
        level_o <= stage3_reg;
        change_o <= 1'b1; // One pulse per accepted level change
      end
    end
  end

endmodule // urs_sync3

// file: verif/urs_sva.sv
`timescale 1ns/1ns
`include "urs_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Port checks of the receive status block
module urs_sva (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`URS_AW-1:0] wb_adr_i,
  input wire [`URS_DW-1:0] wb_dat_o,
  input wire wb_ack_o,
  input wire rx_char_valid_i,
  input wire peer_ready_n_i,
  input wire rx_data_ready_o,
  input wire line_status_irq_o,
  input wire modem_irq_o,
  input wire rx_idle_irq_o
);
  // Taken requests and the reads that clear flags
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire cause = take || rx_char_valid_i;
  wire rd_lsr = take && !wb_we_i && wb_adr_i[7:2] == 6'h05;
  wire rd_msr = take && !wb_we_i && wb_adr_i[7:2] == 6'h06;
  reg pin_reg;
  reg [3:0] quiet_reg;

  // Pin is judged only once it has outlived the synchroniser
  always @(posedge clk_i) begin
    pin_reg <= peer_ready_n_i;
    if (rst_i || pin_reg != peer_ready_n_i) begin
      quiet_reg <= 4'h0;
    end else if (!quiet_reg[3]) begin
      quiet_reg <= quiet_reg + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not a single pulse");
  a_ready_push: assert property (rx_char_valid_i |=> rx_data_ready_o)
    else $error("no data ready after push");
  a_lsr_clear: assert property (rd_lsr && !rx_char_valid_i
    && !$past(rx_char_valid_i) |=> !line_status_irq_o) else $error("line irq kept");
  a_lsr_spare: assert property (rd_lsr |=> wb_dat_o[31:5] == 27'h0000000)
    else $error("line status spare bits set");
  a_msr_level: assert property (rd_msr && quiet_reg[3] |=>
    wb_dat_o[5] == !$past(peer_ready_n_i) && (wb_dat_o & 32'hFFFFFFDD) == 32'h0)
    else $error("modem status read wrong");
  a_msr_clear: assert property (rd_msr && quiet_reg[3] |=> !modem_irq_o)
    else $error("modem irq kept after read");
  a_idle_push: assert property (rx_char_valid_i |=> !rx_idle_irq_o)
    else $error("idle irq kept after push");
  a_idle_empty: assert property (!rx_data_ready_o &&
    !$past(rx_data_ready_o) |-> !rx_idle_irq_o) else $error("idle irq while empty");
  a_line_cause: assert property ($rose(line_status_irq_o) |->
    $past(cause) || $past(cause, 2)) else $error("line irq rose without cause");
  c_idle: cover property (rx_idle_irq_o);
  c_line: cover property (line_status_irq_o);
  c_modem: cover property (modem_irq_o);
endmodule // urs_sva

bind urs_top urs_sva urs_sva_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rx_char_valid_i(rx_char_valid_i), .peer_ready_n_i(peer_ready_n_i),
  .rx_data_ready_o(rx_data_ready_o), .line_status_irq_o(line_status_irq_o),
  .modem_irq_o(modem_irq_o), .rx_idle_irq_o(rx_idle_irq_o));

// file: verif/urs_peer.sv
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Remote serial device: finished characters, baud ticks, peer-ready pin
module urs_peer #(
  parameter int TICK_DIV = 4
) (
  input wire clk_i,
  output logic valid_o,
  output logic [7:0] data_o,
  output logic [2:0] err_o,
  output logic tick_o,
  output logic ready_n_o
);
  int div = 0;

  // Idle levels from time zero
  initial begin
    valid_o = 1'h0;
    data_o = 8'h00;
    err_o = 3'h0;
    tick_o = 1'h0;
    ready_n_o = 1'h1;
  end

  // Slow tick so that a count of ticks is unambiguous
  always @(posedge clk_i) begin
    div <= (div == TICK_DIV - 1) ? 0 : div + 1;
    tick_o <= (div == TICK_DIV - 1);
  end

  // One character; err is {break, framing, parity}; lines flip once released
  task automatic send(input logic [7:0] d, input logic [2:0] e);
    @(posedge clk_i);
    valid_o <= 1'h1;
    data_o <= d;
    err_o <= e;
    @(posedge clk_i);
    valid_o <= 1'h0;
    data_o <= ~d;
    err_o <= ~e;
  endtask

  task automatic set_ready(input logic lvl);
    @(posedge clk_i);
    ready_n_o <= lvl;
  endtask
endmodule // urs_peer

// file: verif/testbench.sv
`timescale 1ns/1ns

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("BAD %0t got %0h want %0h", $time, g, e); end end

module testbench;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  wire [31:0] rdat;
  wire [7:0] data;
  wire [2:0] err;
  wire ack, valid, tick, rdy_n, ready, ls_irq, md_irq, idle_irq, irq;
  int fails = 0;
  int comparisons = 0;
  int i;
  int n;
  int t;

  always #20 clk_i = ~clk_i;

  urs_peer urs_peer_i (.clk_i(clk_i), .valid_o(valid), .data_o(data), .err_o(err),
    .tick_o(tick), .ready_n_o(rdy_n));
  urs_top urs_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .rx_char_valid_i(valid), .rx_char_data_i(data),
    .rx_parity_err_i(err[0]), .rx_frame_err_i(err[1]), .rx_break_i(err[2]),
    .baud_tick_i(tick), .peer_ready_n_i(rdy_n), .rx_data_ready_o(ready),
    .line_status_irq_o(ls_irq), .modem_irq_o(md_irq), .rx_idle_irq_o(idle_irq),
    .irq_o(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // Classic cycle: request held until ack is seen on an edge, data taken there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int k;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    @(posedge clk_i);
    for (k = 0; k < 20 && ack !== 1'h1; k++) @(posedge clk_i);
    q = rdat;
    `CHK(ack, 1'h1)
    {cyc, stb} <= 2'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'h0, a, 32'h00000000, q);
    `CHK(q, e)
  endtask

  task automatic print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    // Reset values, ignored writes, an unmapped place
    rd(8'h18, 32'h0);
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, 32'hFF);
    wr(8'h14, 32'hFF);
    wr(8'h18, 32'hFF);
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h3C, 32'h0);
    // Each error rides with its character and shows at the head only
    wr(8'h04, 32'h4);
    for (i = 0; i < 3; i++) urs_peer_i.send(8'(16 + i), 3'h1 << i);
    `CHK(ls_irq, 1'h1)
    `CHK(irq, 1'h0)
    wr(8'h24, 32'h1);
    `CHK(irq, 1'h1)
    for (i = 0; i < 3; i++) begin
      rd(8'h14, 32'h1 | (32'h4 << i));
      `CHK(ls_irq, 1'h0)
      rd(8'h14, 32'h1);
      rd(8'h00, 32'(16 + i));
    end
    @(posedge clk_i);
    `CHK(ready, 1'h0)
    wr(8'h20, 32'h1);
    `CHK(irq, 1'h0)
    // Full queue, then one character too many
    for (i = 0; i < 64; i++) urs_peer_i.send(8'(i), 3'h0);
    rd(8'h14, 32'h1);
    urs_peer_i.send(8'hEE, 3'h0);
    @(posedge clk_i);
    `CHK(ls_irq, 1'h1)
    rd(8'h14, 32'h3);
    rd(8'h14, 32'h1);
    for (i = 0; i < 64; i++) rd(8'h00, 32'(i));
    rd(8'h00, 32'h0);
    // Idle timeout with both enables, then with only one of them
    for (i = 0; i < 3; i++) begin
      wr(8'h04, i == 1 ? 32'h0 : 32'h1);
      wr(8'h1C, i == 2 ? 32'h3 : 32'h83);
      urs_peer_i.send(8'h5A, 3'h0);
      t = 0;
      for (n = 0; n < 40 && idle_irq !== 1'h1; n++) begin
        @(posedge clk_i);
        t += tick;
      end
      `CHK(idle_irq, i == 0)
      if (i == 0) begin
        `CHK(t, 3)
        urs_peer_i.send(8'hA5, 3'h0);
        @(posedge clk_i);
        `CHK(idle_irq, 1'h0)
        rd(8'h00, 32'h5A);
      end
      rd(8'h00, i == 0 ? 32'hA5 : 32'h5A);
      @(posedge clk_i);
      `CHK(idle_irq, 1'h0)
    end
    // Peer-ready pin: level, change flag, interrupt
    wr(8'h04, 32'h8);
    wr(8'h24, 32'h2);
    urs_peer_i.set_ready(1'h0);
    repeat (10) @(posedge clk_i);
    `CHK(md_irq, 1'h1)
    `CHK(irq, 1'h1)
    rd(8'h18, 32'h22);
    `CHK(md_irq, 1'h0)
    wr(8'h18, 32'h0);
    rd(8'h18, 32'h20);
    wr(8'h20, 32'h2);
    `CHK(irq, 1'h0)
    urs_peer_i.set_ready(1'h1);
    repeat (10) @(posedge clk_i);
    rd(8'h18, 32'h2);
    print_verdict;
  end

  // Watchdog far beyond the roughly six hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    print_verdict;
  end
endmodule // testbench
